/* File: totalizer_pkg.sv */
package totalizer_pkg;

  // Register byte offsets on the control bus.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] TOTAL_OFFSET  = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // Control register field positions.
  localparam int RANGE_LSB    = 0;
  localparam int LINE50_BIT   = 3;
  localparam int MODE2_BIT    = 4;
  localparam int FRONT_EN_BIT = 5;
  localparam int CLEAR_BIT    = 6;

  // Range-select codes.
  localparam logic [2:0] RANGE_COUNT   = 3'h0;
  localparam logic [2:0] RANGE_FACTORY = 3'h7;

  // Control values after reset: count range, 60 Hz line, mode 1, front button on.
  localparam logic [2:0] RANGE_RESET    = 3'h0;
  localparam logic       LINE50_RESET   = 1'b0;
  localparam logic       MODE2_RESET    = 1'b0;
  localparam logic       FRONT_EN_RESET = 1'b1;

  // Line cycles per tenth of a second on each line frequency.
  localparam logic [17:0] TENTH_CYCLES_60HZ = 18'h00006;
  localparam logic [17:0] TENTH_CYCLES_50HZ = 18'h00005;

  // Tenths of a second per display unit, indexed by range code 1 to 6.
  localparam logic [17:0] UNIT_TENTHS_SEC_T  = 18'h00001;
  localparam logic [17:0] UNIT_TENTHS_SEC    = 18'h0000a;
  localparam logic [17:0] UNIT_TENTHS_MIN_T  = 18'h0003c;
  localparam logic [17:0] UNIT_TENTHS_MIN    = 18'h00258;
  localparam logic [17:0] UNIT_TENTHS_HR_T   = 18'h00e10;
  localparam logic [17:0] UNIT_TENTHS_HR     = 18'h08ca0;

  // Width of the display total: one half digit over four decimal digits.
  localparam int TOTAL_W = 17;
  localparam logic [16:0] TOTAL_RESET = 17'h00000;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic       clear;
    logic       front_en;
    logic       mode2;
    logic       line50;
    logic [2:0] range;
  } ctrl_type;

  typedef struct packed {
    logic        timing;
    logic        counting;
    logic [2:0]  range;
    logic        tenths_point;
  } annunc_type;

endpackage

/* File: line_totalizer.sv */
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1 - In a time range, service-line cycles pass a divider whose ratio the range picks.
// RULE2 - Six time ranges exist: seconds, minutes and hours, each in tenths or whole units.
// RULE3 - In count operation external events are totalled up to 19999.
// RULE4 - Count mode 1 registers one count when the applied count voltage goes away.
// RULE5 - Count mode 2 registers one count at the leading edge of a contact closure.
// RULE6 - A remote reset clears the total, well within 10 ms.
// RULE7 - With the front-button option, the front pushbutton clears the total as well.
// RULE8 - Loss of line voltage leaves the total unchanged and is not a reset.
// RULE9 - A voltage count pulse is held on at least 8 ms and off at least 16 ms.
// RULE10 - A contact stays closed at least 4 ms and open at least 8 ms per event.
// RULE11 - The divider suits a 60 Hz line and can be set for a 50 Hz line.
// RULE12 - Annunciators show timing or counting and the active time range.
// RULE13 - The total is shown on four full digits and a leading half digit.
// RULE14 - A range code picks count, a time range or the factory setting, with ratio and point.
module line_totalizer
  import totalizer_pkg::*;
#(
  parameter logic [17:0] FACTORY_RATIO = 18'h0003c,
  parameter logic        FACTORY_TENTHS = 1'b0
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Field wiring and reset switches, already in the clock domain.
  input  wire logic               line_in,
  input  wire logic               count_voltage,
  input  wire logic               contact_closed,
  input  wire logic               remote_reset,
  input  wire logic               front_reset,
  // Register bus, write side.
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        awaddr,
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  // Register bus, read side.
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [31:0]        araddr,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  // Front panel.
  output logic [TOTAL_W-1:0]      display_total,
  output annunc_type              annunc
);

  ctrl_type             ctrl_q;
  logic [TOTAL_W-1:0]   total_q;
  logic [17:0]          presc_q;
  logic [17:0]          ratio;
  logic                 line_q;
  logic                 volt_q;
  logic                 contact_q;
  logic                 line_rise;
  logic                 count_event;
  logic                 time_tick;
  logic                 clear_req;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 tenths;
  logic                 ctrl_hit;
  logic [TOTAL_W-1:0]   total_d;
  logic [31:0]          rd_data_d;
  logic [1:0]           rd_resp_d;

  // Adds one to the half digit and four decimal digits, wrapping after 19999.
  function automatic logic [TOTAL_W-1:0] bcd_inc(input logic [TOTAL_W-1:0] v);
    logic [TOTAL_W-1:0] r;
    logic               c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[4*i +: 4] == 4'h9) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    if (c) begin
      r[16] = ~r[16];
    end
    return r;
  endfunction

  // Line cycles per display unit for the selected range and line frequency.
  // RULE1 RULE2 RULE11 RULE14 divider ratio
  always_comb begin
    logic [17:0] base;
    base = ctrl_q.line50 ? TENTH_CYCLES_50HZ : TENTH_CYCLES_60HZ;
    tenths = 1'b0;
    case (ctrl_q.range)
      3'h1: begin
        ratio = 18'(base * UNIT_TENTHS_SEC_T);
        tenths = 1'b1;
      end
      3'h2: ratio = 18'(base * UNIT_TENTHS_SEC);
      3'h3: begin
        ratio = 18'(base * UNIT_TENTHS_MIN_T);
        tenths = 1'b1;
      end
      3'h4: ratio = 18'(base * UNIT_TENTHS_MIN);
      3'h5: begin
        ratio = 18'(base * UNIT_TENTHS_HR_T);
        tenths = 1'b1;
      end
      3'h6: ratio = 18'(base * UNIT_TENTHS_HR);
      RANGE_FACTORY: begin
        ratio = FACTORY_RATIO;
        tenths = FACTORY_TENTHS;
      end
      default: ratio = 18'h00001;
    endcase
  end

  // Previous input levels for edge detection; inputs are already synchronous.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q    <= 1'b0;
      volt_q    <= 1'b0;
      contact_q <= 1'b0;
    end else begin
      line_q    <= line_in;
      volt_q    <= count_voltage;
      contact_q <= contact_closed;
    end
  end

  assign line_rise = line_in & ~line_q;

  // RULE4 RULE5 count edge choice
  // The minimum on and off times of the source keep each event far apart here.
  // There is no debounce: a bouncing contact would count every bounce, so the
  // source timing limits are part of the contract rather than repaired here.
  assign count_event = ctrl_q.mode2 ? (contact_closed & ~contact_q)
                                    : (volt_q & ~count_voltage);

  // RULE6 RULE7 reset sources
  assign clear_req = remote_reset | (front_reset & ctrl_q.front_en) | ctrl_q.clear;

  // Prescaler over line cycles; a missing line simply holds it still.
  // After a range change a stale count above the new ratio ends at the next line edge.
  // RULE1 RULE8 line divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 18'h00000;
    end else if (clear_req || ctrl_q.range == RANGE_COUNT) begin
      presc_q <= 18'h00000;
    end else if (line_rise) begin
      presc_q <= (presc_q >= ratio - 18'h00001) ? 18'h00000 : presc_q + 18'h00001;
    end
  end

  assign time_tick = line_rise && (ctrl_q.range != RANGE_COUNT)
                     && (presc_q >= ratio - 18'h00001);

  // Next total; a clear outranks an increment that falls in the same cycle.
  // RULE3 RULE6 RULE7 next total
  always_comb begin
    total_d = total_q;
    if (clear_req) begin
      total_d = TOTAL_RESET;
    end else if (ctrl_q.range == RANGE_COUNT ? count_event : time_tick) begin
      total_d = bcd_inc(total_q);
    end
  end

  // Total accumulator; only a reset request clears it, never a line outage.
  // RULE3 RULE8 RULE13 total update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_q <= TOTAL_RESET;
    end else begin
      total_q <= total_d;
    end
  end

  // Display is registered so a carry rippling through the digits is never seen.
  // RULE13 display
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_total <= TOTAL_RESET;
    end else begin
      display_total <= total_q;
    end
  end

  // Annunciators are registered levels that follow the range one cycle late.
  // RULE12 RULE14 annunciators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      annunc <= '0;
    end else begin
      annunc.counting     <= (ctrl_q.range == RANGE_COUNT);
      annunc.timing       <= (ctrl_q.range != RANGE_COUNT);
      annunc.range        <= ctrl_q.range;
      annunc.tenths_point <= tenths;
    end
  end

  // Write channel: address and data are taken together once both are offered,
  // so a master may present them in either order and the slave waits for both.
  assign wr_fire = awvalid && wvalid && !awready && !bvalid;

  // Only the exact control word address decodes; every other write is refused.
  assign ctrl_hit = (awaddr == 32'(CTRL_OFFSET));

  // Ready pulses last one cycle; a new transfer waits until the response is gone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= wr_fire;
      wready  <= wr_fire;
    end
  end

  // Write response stands until the master's bready is seen.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (awready) begin
      bvalid <= 1'b1;
      bresp  <= ctrl_hit ? RESP_OKAY : RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control register; the clear bit is a one-cycle pulse and reads back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q.range    <= RANGE_RESET;
      ctrl_q.line50   <= LINE50_RESET;
      ctrl_q.mode2    <= MODE2_RESET;
      ctrl_q.front_en <= FRONT_EN_RESET;
      ctrl_q.clear    <= 1'b0;
    end else begin
      ctrl_q.clear <= 1'b0;
      if (awready && ctrl_hit && wstrb[0]) begin
        ctrl_q.range    <= wdata[RANGE_LSB +: 3];
        ctrl_q.line50   <= wdata[LINE50_BIT];
        ctrl_q.mode2    <= wdata[MODE2_BIT];
        ctrl_q.front_en <= wdata[FRONT_EN_BIT];
        ctrl_q.clear    <= wdata[CLEAR_BIT];
      end
    end
  end

  // Read channel: one address at a time, data one cycle after the handshake.
  assign rd_fire = arvalid && !arready && !rvalid;

  // Read word for the address on the bus; the master holds it until arready.
  // RULE12 RULE13 RULE14 register read
  always_comb begin
    rd_data_d = 32'h00000000;
    rd_resp_d = RESP_OKAY;
    case (araddr)
      32'(CTRL_OFFSET): rd_data_d = 32'({ctrl_q.front_en, ctrl_q.mode2,
                                          ctrl_q.line50, ctrl_q.range});
      32'(TOTAL_OFFSET): rd_data_d = 32'(total_q);
      32'(STATUS_OFFSET): rd_data_d = 32'({presc_q, tenths,
                                            ctrl_q.range == RANGE_COUNT});
      default: rd_resp_d = RESP_DECERR;
    endcase
  end

  // Read answer stands until the master's rready is seen.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= rd_fire;
      if (arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_data_d;
        rresp  <= rd_resp_d;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: totalizer_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module totalizer_chk
  import totalizer_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               remote_reset,
  input wire logic               awready,
  input wire logic               wready,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [1:0]         bresp,
  input wire logic               arready,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [31:0]        rdata,
  input wire logic [TOTAL_W-1:0] display_total,
  input wire annunc_type         annunc
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Total, display and annunciator relations.
  chk_remote_clear: assert property (remote_reset |-> ##2 display_total == TOTAL_RESET)
    else $error("remote reset left a total");
  chk_bcd_digits: assert property (display_total[3:0] < 4'ha && display_total[7:4] < 4'ha
    && display_total[11:8] < 4'ha && display_total[15:12] < 4'ha) else $error("bad digit");
  chk_count_step: assert property ($changed(display_total) |-> display_total[3:0] == 4'h0
    || display_total[3:0] == $past(display_total[3:0]) + 4'h1) else $error("total jumped");
  chk_annunc_mode: assert property (!(annunc.timing && annunc.counting)
    && annunc.timing == (annunc.range != RANGE_COUNT)) else $error("annunciator mismatch");
  // Bus handshake timing.
  chk_write_accept: assert property (awready |-> wready ##1 !awready && bvalid)
    else $error("write accept wrong");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (arready |=> !arready && rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  // Main scenarios reached.
  cover property (remote_reset);
  cover property (bvalid && bready && bresp == RESP_DECERR);
  cover property (annunc.timing && display_total != TOTAL_RESET);
endmodule
bind line_totalizer totalizer_chk totalizer_chk_inst (.aclk, .aresetn, .remote_reset, .awready,
  .wready, .bvalid, .bready, .bresp, .arready, .rvalid, .rready, .rdata, .display_total, .annunc);
`default_nettype wire

/* File: field_wiring.sv */
`timescale 1ns/10ps
`default_nettype none
module field_wiring (
  input  wire logic        aclk,
  input  wire logic        start,
  input  wire logic [1:0]  sel,
  input  wire logic [15:0] num,
  output logic             busy,
  output logic             line_in,
  output logic             count_voltage,
  output logic             contact_closed
);
  // Spans in clock cycles; one cycle stands for a millisecond to keep runs short.
  // minimum on/off spans
  function automatic logic [4:0] span(input logic [1:0] s, input logic off);
    case (s)
      2'h1: return off ? 5'h10 : 5'h08;
      2'h2: return off ? 5'h08 : 5'h04;
      default: return 5'h02;
    endcase
  endfunction
  // Idle means no line, no voltage and an open contact.
  // line may stop
  initial begin
    {busy, line_in, count_voltage, contact_closed} = 4'h0;
    forever begin
      @(posedge aclk);
      if (start) begin
        busy <= 1'b1;
        repeat (num) begin
          {contact_closed, count_voltage, line_in} <= 3'h1 << sel;
          repeat (span(sel, 1'b0)) @(posedge aclk);
          {contact_closed, count_voltage, line_in} <= 3'h0;
          repeat (span(sel, 1'b1)) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import totalizer_pkg::*;
;
  logic               aclk = 1'b0, aresetn = 1'b0, remote_reset = 1'b0, front_reset = 1'b0;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic               rready = 1'b0, start = 1'b0, lf;
  logic [1:0]         sel = 2'h0, bresp, rresp, resp;
  logic [2:0]         r;
  logic [15:0]        num = 16'h0001, n;
  logic [31:0]        awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d, rdata;
  logic [31:0]        seed = 32'h00011462;
  logic               awready, wready, bvalid, arready, rvalid, busy;
  logic               line_in, count_voltage, contact_closed;
  logic [TOTAL_W-1:0] display_total;
  annunc_type         annunc;
  int                 num_errors = 0, compares = 0;
  line_totalizer line_totalizer_inst (.aclk, .aresetn, .line_in, .count_voltage,
    .contact_closed, .remote_reset, .front_reset, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .display_total, .annunc);
  field_wiring field_wiring_inst (.aclk, .start, .sel, .num, .busy, .line_in,
    .count_voltage, .contact_closed);
  // Bus clock at 100 MHz.
  always #5 aclk = ~aclk;
  // Expected-value helpers.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] bcd(input logic [15:0] v);
    logic [31:0] b;
    b = 32'h0;
    for (int i = 0; i < 4; i++) begin
      b[i*4 +: 4] = 4'(v % 16'h000a);
      v = v / 16'h000a;
    end
    return b;
  endfunction
  function automatic logic [15:0] ratio(input logic [2:0] rg, input logic f);
    logic [15:0] b;
    b = f ? 16'h0005 : 16'h0006;
    case (rg)
      3'h1: return b;
      3'h2: return b * 16'h000a;
      3'h3: return b * 16'h003c;
      default: return b * 16'h0258;
    endcase
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus master: each channel is released when taken; the wait ends only on the answer.
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic expect_rd(input logic [31:0] a, input logic [31:0] e);
    rd(a, d, resp);
    check(d, e);
  endtask
  // Field events: the partner runs the pulses while busy is high.
  task automatic field(input logic [1:0] s, input logic [15:0] k);
    @(posedge aclk);
    sel <= s;
    num <= k;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask
  task automatic press(input logic front);
    @(posedge aclk);
    {front_reset, remote_reset} <= {front, !front};
    @(posedge aclk);
    {front_reset, remote_reset} <= 2'h0;
  endtask
  task automatic test_done();
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, well beyond the roughly 17000 cycles the sequence needs.
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    test_done();
  end
  // Main sequence: reset, refused accesses, both count modes, resets, time ranges.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    expect_rd(CTRL_OFFSET, 32'h00000020);
    expect_rd(TOTAL_OFFSET, 32'h0);
    rd(32'h0000000c, d, resp);
    check({d[29:0], resp}, {30'h0, RESP_DECERR});
    wr(TOTAL_OFFSET, 32'h00000001, resp);
    check({30'h0, resp}, {30'h0, RESP_DECERR});
    for (int m = 0; m < 2; m++) begin
      n = 16'(rnd() & 32'h7) + 16'h0001;
      wr(CTRL_OFFSET, 32'h00000060 | (32'(m) << MODE2_BIT), resp);
      field(2'(m + 1), n);
      expect_rd(TOTAL_OFFSET, bcd(n));
      check(32'(display_total), bcd(n));
      field(2'(2 - m), 16'h0002);
      expect_rd(TOTAL_OFFSET, bcd(n));
      press(m[0]);
      expect_rd(TOTAL_OFFSET, 32'h0);
    end
    wr(CTRL_OFFSET, 32'h00000050, resp);
    field(2'h2, 16'h0003);
    press(1'b1);
    expect_rd(TOTAL_OFFSET, 32'h00000003);
    expect_rd(CTRL_OFFSET, 32'h00000010);
    check(32'(annunc), 32'h00000010);
    for (int i = 0; i < 8; i++) begin
      r = (i < 7) ? 3'(i + 1) : 3'h1;
      lf = (i == 7);
      wr(CTRL_OFFSET, 32'h00000060 | r | (32'(lf) << LINE50_BIT), resp);
      expect_rd(STATUS_OFFSET, {30'h0, r[0] && r != 3'h7, 1'b0});
      check(32'(annunc), {26'h0, 1'b1, 1'b0, r, r[0] && r != 3'h7});
      if (r < 3'h5) begin
        field(2'h0, ratio(r, lf) - 16'h0001);
        expect_rd(TOTAL_OFFSET, 32'h0);
        field(2'h0, 16'h0001);
        expect_rd(TOTAL_OFFSET, 32'h00000001);
        check(32'(display_total), 32'h00000001);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
